// >>> common/serial_iface_pkg.sv
package serial_iface_pkg;
    // Register byte addresses on the AXI4-Lite bus
    localparam logic [3:0] MODE_CTRL_OFFSET = 4'h0;
    localparam logic [3:0] FORMAT_CTRL_OFFSET = 4'h4;
    localparam logic [3:0] IRQ_STATUS_OFFSET = 4'h8;
    localparam logic [3:0] IRQ_MASK_OFFSET = 4'hC;
    // Mode control fields
    localparam int MODE_FIELD_LSB = 5;
    localparam int UART_MODE_BIT = 4;
    localparam int DEBOUNCE_LSB = 2;
    localparam int ENABLE_BIT = 1;
    localparam int INCOMPLETE_BIT = 0;
    // Format control fields
    localparam int CLOCK_BASE_BIT = 5;
    localparam int CLOCK_EDGE_BIT = 4;
    localparam int SHIFT_ORDER_BIT = 3;
    localparam int SELECT_EN_BIT = 2;
    localparam int COLLISION_BIT = 1;
    localparam int COMPLETE_BIT = 0;
    // Reset values
    localparam logic [7:0] MODE_CTRL_RESET = 8'hE0;
    localparam logic [7:0] FORMAT_CTRL_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // Interrupt status bits
    localparam int IRQ_INCOMPLETE_BIT = 0;
    localparam int IRQ_COMPLETE_BIT = 1;
    // Operating modes, AXI response codes and link states
    localparam logic [2:0] MODE_SLAVE_SPI = 3'h5;
    localparam logic [2:0] MODE_SLAVE_I2C = 3'h6;
    localparam logic [2:0] MODE_UNUSED = 3'h7;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        LINK_OFF = 3'b001,
        LINK_IDLE = 3'b010,
        LINK_BUSY = 3'b100
    } link_state_t;
endpackage : serial_iface_pkg

// >>> common/sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sync_if;
    logic rawSelN;
    logic rawClk;
    logic selN;
    logic sclk;
    modport src (output rawSelN, output rawClk, input selN, input sclk);
    modport syn (input rawSelN, input rawClk, output selN, output sclk);
endinterface : sync_if
`default_nettype wire

// >>> verilog/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
    input wire logic clk,
    input wire logic resetn,
    sync_if.syn sif
);
    logic [1:0] selStage_q;
    logic [1:0] clkStage_q;
    // Both pins idle high after reset, so no false edge follows it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            selStage_q <= 2'h3;
            clkStage_q <= 2'h3;
        end else begin
            selStage_q <= {selStage_q[0], sif.rawSelN};
            clkStage_q <= {clkStage_q[0], sif.rawClk};
        end
    end
    assign sif.selN = selStage_q[1];
    assign sif.sclk = clkStage_q[1];
endmodule : pin_sync
`default_nettype wire

// >>> verilog/serial_iface_enable_status.sv
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module serial_iface_enable_status (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic selectNIn,
    input wire logic serialClkIn,
    input wire logic byteDone,
    input wire logic i2cTxDirIn,
    input wire logic i2cAckDriveIn,
    output logic selectNInputEn,
    output logic pinsActive,
    output logic moduleClockOn,
    output logic i2cFlagReset,
    output logic [1:0] debounceActive,
    output logic [2:0] masterRateSel,
    output logic spiSlaveMode,
    output logic i2cSlaveMode,
    output logic irq
);
    import serial_iface_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] modeCtrl_q;
    logic [7:0] formatCtrl_q;
    logic [1:0] irqStatus_q;
    logic [1:0] irqMask_q;
    logic enablePrev_q;
    logic selPrev_q;
    logic sclkPrev_q;
    logic [3:0] edgeCount_q;
    link_state_t link_q;
    logic [3:0] awaddr_q;
    logic awHeld_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wHeld_q;
    logic selN;
    logic sclk;
    logic wrFire;
    logic wrMode;
    logic wrFormat;
    logic wrStatus;
    logic wrMask;
    logic ifaceEnable;
    logic isSpi;
    logic isSpiSlave;
    logic isI2c;
    logic slaveArmed;
    logic earlyDeselect;
    logic sampleEdge;
    logic completeSet;

    sync_if sif ();
    assign sif.rawSelN = selectNIn;
    assign sif.rawClk = serialClkIn;
    pin_sync syncInst (
        .clk(clk),
        .resetn(resetn),
        .sif(sif)
    );
    assign selN = sif.selN;
    assign sclk = sif.sclk;

    function automatic logic [7:0] mergeByte(input logic [7:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
        mergeByte = strb[0] ? data[7:0] : old;
    endfunction : mergeByte

    ////////////////////////////////////////////////////////////////////////////
    // Mode decoding
    assign ifaceEnable = modeCtrl_q[ENABLE_BIT];
    assign isSpi = !modeCtrl_q[UART_MODE_BIT] && (modeCtrl_q[7:5] < MODE_SLAVE_I2C);
    assign isSpiSlave = !modeCtrl_q[UART_MODE_BIT] && (modeCtrl_q[7:5] == MODE_SLAVE_SPI);
    assign isI2c = !modeCtrl_q[UART_MODE_BIT] && (modeCtrl_q[7:5] == MODE_SLAVE_I2C);
    assign slaveArmed = isSpiSlave && ifaceEnable && formatCtrl_q[SELECT_EN_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data taken in either order
    assign wrFire = awHeld_q && wHeld_q && !bvalid;
    assign wrMode = wrFire && (awaddr_q == MODE_CTRL_OFFSET);
    assign wrFormat = wrFire && (awaddr_q == FORMAT_CTRL_OFFSET);
    assign wrStatus = wrFire && (awaddr_q == IRQ_STATUS_OFFSET) && wstrb_q[0];
    assign wrMask = wrFire && (awaddr_q == IRQ_MASK_OFFSET) && wstrb_q[0];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            awHeld_q <= 1'b0;
            awaddr_q <= 4'h0;
            awready <= 1'b0;
        end else begin
            awready <= !awHeld_q && !awready && awvalid;
            if (awvalid && awready) begin
                awHeld_q <= 1'b1;
                awaddr_q <= {awaddr[3:2], 2'h0};
            end else if (wrFire) begin
                awHeld_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wHeld_q <= 1'b0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            wready <= 1'b0;
        end else begin
            wready <= !wHeld_q && !wready && wvalid;
            if (wvalid && wready) begin
                wHeld_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end else if (wrFire) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bvalid <= 1'b0;
            bresp <= AXI_OKAY;
        end else if (wrFire) begin
            bvalid <= 1'b1;
            bresp <= (awaddr_q > IRQ_MASK_OFFSET) ? AXI_SLVERR : AXI_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= AXI_OKAY;
        end else begin
            arready <= !arready && !rvalid && arvalid;
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= AXI_OKAY;
                case (araddr[3:2])
                    2'h0: rdata <= {24'h0, modeCtrl_q};
                    2'h1: rdata <= {24'h0, formatCtrl_q};
                    2'h2: rdata <= {30'h0, irqStatus_q};
                    default: rdata <= {30'h0, irqMask_q};
                endcase
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link watch: counts sampling edges within a byte
    // Capture edge is rising when base level and edge select agree
    assign sampleEdge = (sclk != sclkPrev_q)
        && (sclk == !(formatCtrl_q[CLOCK_BASE_BIT] ^ formatCtrl_q[CLOCK_EDGE_BIT]));
    // A finished byte clears the count, so a deselect after it is not early
    assign earlyDeselect = slaveArmed && (link_q == LINK_BUSY) && selN && !selPrev_q
        && !byteDone && (edgeCount_q != 4'h0);
    assign completeSet = earlyDeselect || (isSpi && ifaceEnable && byteDone);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            selPrev_q <= 1'b1;
            sclkPrev_q <= 1'b1;
        end else begin
            selPrev_q <= selN;
            sclkPrev_q <= sclk;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            link_q <= LINK_OFF;
            edgeCount_q <= 4'h0;
        end else begin
            case (link_q)
                LINK_OFF: begin
                    edgeCount_q <= 4'h0;
                    if (slaveArmed) begin
                        link_q <= LINK_IDLE;
                    end
                end
                LINK_IDLE: begin
                    edgeCount_q <= 4'h0;
                    if (!slaveArmed) begin
                        link_q <= LINK_OFF;
                    end else if (!selN) begin
                        link_q <= LINK_BUSY;
                    end
                end
                LINK_BUSY: begin
                    if (!slaveArmed) begin
                        link_q <= LINK_OFF;
                    end else if (selN) begin
                        link_q <= LINK_IDLE;
                    end else if (byteDone) begin
                        edgeCount_q <= 4'h0;
                    end else if (sampleEdge) begin
                        edgeCount_q <= edgeCount_q + 4'h1;
                    end
                end
                default: link_q <= LINK_OFF;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode control register; hardware set beats software clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            modeCtrl_q <= MODE_CTRL_RESET;
        end else begin
            if (wrMode) begin
                modeCtrl_q <= mergeByte(modeCtrl_q, wdata_q, wstrb_q);
            end
            if (earlyDeselect) begin
                modeCtrl_q[INCOMPLETE_BIT] <= 1'b1;
            end
        end
    end

    // Format control: plain storage apart from the hardware-set complete flag; never cleared by enable
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            formatCtrl_q <= FORMAT_CTRL_RESET;
        end else begin
            if (wrFormat) begin
                formatCtrl_q <= mergeByte(formatCtrl_q, wdata_q, wstrb_q);
            end
            // Early deselect or a finished SPI byte sets complete; a software write of incomplete does not
            if (completeSet) begin
                formatCtrl_q[COMPLETE_BIT] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, write one to clear, set wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqStatus_q <= IRQ_RESET;
            irqMask_q <= IRQ_RESET;
        end else begin
            if (wrMask) begin
                irqMask_q <= wdata_q[1:0];
            end
            irqStatus_q <= (irqStatus_q & ~(wrStatus ? wdata_q[1:0] : 2'h0))
                | {completeSet, earlyDeselect};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus_q & irqMask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin role, power and I2C enable behaviour
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enablePrev_q <= 1'b0;
            pinsActive <= 1'b0;
            moduleClockOn <= 1'b0;
            selectNInputEn <= 1'b0;
            i2cFlagReset <= 1'b0;
            debounceActive <= 2'h0;
            masterRateSel <= 3'h0;
            spiSlaveMode <= 1'b0;
            i2cSlaveMode <= 1'b0;
        end else begin
            enablePrev_q <= ifaceEnable;
            pinsActive <= ifaceEnable && (isSpi || isI2c);
            moduleClockOn <= ifaceEnable;
            selectNInputEn <= ifaceEnable && isSpi && formatCtrl_q[SELECT_EN_BIT];
            // Tx direction and ack drive stay in their own block; only flags reset
            i2cFlagReset <= isI2c && ifaceEnable && !enablePrev_q;
            debounceActive <= isI2c ? modeCtrl_q[3:2] : 2'h0;
            masterRateSel <= (isSpi && !isSpiSlave) ? modeCtrl_q[7:5] : 3'h0;
            spiSlaveMode <= isSpiSlave && ifaceEnable;
            i2cSlaveMode <= isI2c && ifaceEnable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    cntIdle_a: assert property (@(posedge clk) disable iff (!resetn)
        (link_q != LINK_BUSY) |=> (edgeCount_q == 4'h0) || (link_q == LINK_BUSY))
        else $error("edge count not cleared outside a byte");
    incSet_a: assert property (@(posedge clk) disable iff (!resetn)
        earlyDeselect |=> modeCtrl_q[INCOMPLETE_BIT] && formatCtrl_q[COMPLETE_BIT])
        else $error("early deselect did not set both flags");
    incIrq_a: assert property (@(posedge clk) disable iff (!resetn)
        earlyDeselect && irqMask_q[IRQ_INCOMPLETE_BIT] && !wrMask |-> ##2 irq)
        else $error("incomplete transfer gave no interrupt");
    swNoTrf_a: assert property (@(posedge clk) disable iff (!resetn)
        wrMode && !earlyDeselect && !byteDone && !wrFormat && !formatCtrl_q[COMPLETE_BIT]
        |=> !formatCtrl_q[COMPLETE_BIT])
        else $error("software write set complete flag");
    incHold_a: assert property (@(posedge clk) disable iff (!resetn)
        !modeCtrl_q[INCOMPLETE_BIT] && !earlyDeselect && !wrMode
        |=> !modeCtrl_q[INCOMPLETE_BIT])
        else $error("incomplete flag rose with no cause");
    offPins_a: assert property (@(posedge clk) disable iff (!resetn)
        !ifaceEnable ##1 !ifaceEnable |-> !pinsActive && !moduleClockOn)
        else $error("pins active while disabled");
    formatKeep_a: assert property (@(posedge clk) disable iff (!resetn)
        $rose(ifaceEnable)
        |-> $stable(formatCtrl_q))
        else $error("format control changed on enable");
    debounce_a: assert property (@(posedge clk) disable iff (!resetn)
        !isI2c |=> debounceActive == 2'h0)
        else $error("debounce active outside I2C");
    selEn_a: assert property (@(posedge clk) disable iff (!resetn)
        !formatCtrl_q[SELECT_EN_BIT] |=> !selectNInputEn)
        else $error("select pin enabled while disabled");
    i2cRst_a: assert property (@(posedge clk) disable iff (!resetn)
        i2cFlagReset |-> $past(isI2c) && $past(ifaceEnable) && !$past(enablePrev_q))
        else $error("I2C flag reset without enable rise");
    wrSeen_c: cover property (@(posedge clk) disable iff (!resetn) wrFire);
    early_c: cover property (@(posedge clk) disable iff (!resetn) earlyDeselect);
    irqOn_c: cover property (@(posedge clk) disable iff (!resetn) $rose(irq));
    i2cOn_c: cover property (@(posedge clk) disable iff (!resetn) i2cFlagReset);
endmodule : serial_iface_enable_status
`default_nettype wire

// >>> bench/spi_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
    output logic selN,
    output logic sclk
);
    localparam int HALF_NS = 40;
    initial begin
        selN = 1'b1;
        sclk = 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    // Clock stands still at base level outside frames; high base suits format 0x04
    // Pin changes land off the system clock edge
    task automatic select();
        #1;
        selN = 1'b0;
        #(HALF_NS);
    endtask : select
    task automatic pulses(input int n);
        repeat (2 * n) begin
            sclk = ~sclk;
            #(HALF_NS);
        end
    endtask : pulses
    // Raising select after a sampling edge but before byteDone is the early-deselect fault
    task automatic deselect();
        #1;
        selN = 1'b1;
        #(HALF_NS);
    endtask : deselect
endmodule : spi_master_model
`default_nettype wire

// >>> bench/tb_serial_iface_enable_status.sv
`timescale 1ns/10ps
`default_nettype none
module tb_serial_iface_enable_status;
    import serial_iface_pkg::*;
    typedef struct {logic [7:0] mode; logic [8:0] outs;} row_t;
    logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, selN, sclk, byteDone;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, debounceActive;
    logic selectNInputEn, pinsActive, moduleClockOn, i2cFlagReset;
    logic spiSlaveMode, i2cSlaveMode, irq;
    logic [2:0] masterRateSel;
    logic [7:0] v;
    int failures, n_tests, flagPulses, base, i;
    // Outputs packed as pins, spiSlave, i2cSlave, selectEn, debounce, rate
    row_t rows [10] = '{'{8'h0E, 9'h120}, '{8'h2E, 9'h121}, '{8'h4E, 9'h122},
        '{8'h6E, 9'h123}, '{8'h8E, 9'h124}, '{8'hAE, 9'h1A0}, '{8'hCE, 9'h158},
        '{8'hC6, 9'h148}, '{8'hEE, 9'h000}, '{8'h1E, 9'h000}};

    serial_iface_enable_status dut (.clk(clk), .resetn(resetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .selectNIn(selN), .serialClkIn(sclk), .byteDone(byteDone),
        .i2cTxDirIn(1'b0), .i2cAckDriveIn(1'b0), .selectNInputEn(selectNInputEn),
        .pinsActive(pinsActive), .moduleClockOn(moduleClockOn),
        .i2cFlagReset(i2cFlagReset), .debounceActive(debounceActive),
        .masterRateSel(masterRateSel), .spiSlaveMode(spiSlaveMode),
        .i2cSlaveMode(i2cSlaveMode), .irq(irq));
    spi_master_model master (.selN(selN), .sclk(sclk));

    always #2.5 clk = ~clk;
    always @(posedge clk) if (i2cFlagReset === 1'b1) flagPulses++;
    ////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t %s: seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check
    task automatic timeout();
        failures++;
        $display("ERROR %0t wait ran out", $time);
        test_done();
    endtask : timeout
    task automatic axiWrite(input logic [3:0] a, input logic [7:0] d);
        logic done;
        done = 1'b0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int k = 0; k < 100 && !done; k++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                done = 1'b1;
                check(bresp, AXI_OKAY, "bresp");
            end
        end
        bready <= 1'b0;
        if (!done) timeout();
        @(posedge clk);
    endtask : axiWrite
    task automatic axiRead(input logic [3:0] a, input logic [7:0] exp, input string what);
        logic done;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int k = 0; k < 100 && !done; k++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                done = 1'b1;
                check(rdata, {24'h000000, exp}, what);
                check(rresp, AXI_OKAY, "rresp");
            end
        end
        rready <= 1'b0;
        if (!done) timeout();
        @(posedge clk);
    endtask : axiRead
    task automatic waitIrq();
        for (i = 0; i < 60 && irq !== 1'b1; i++) @(posedge clk);
        if (irq !== 1'b1) timeout();
    endtask : waitIrq
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, byteDone} = 6'h00;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        repeat (5) @(posedge clk);
        check({pinsActive, irq, moduleClockOn}, 3'h0, "outputs in reset");
        resetn <= 1'b1;
        @(posedge clk);
        axiRead(MODE_CTRL_OFFSET, 8'hE0, "mode reset");
        axiRead(FORMAT_CTRL_OFFSET, 8'h00, "format reset");
        axiRead(IRQ_STATUS_OFFSET, 8'h00, "status reset");
        axiRead(IRQ_MASK_OFFSET, 8'h00, "mask reset");
        axiWrite(FORMAT_CTRL_OFFSET, 8'hFF);
        axiRead(FORMAT_CTRL_OFFSET, 8'hFF, "format all ones");
        axiWrite(FORMAT_CTRL_OFFSET, 8'h04);
        foreach (rows[k]) begin
            axiWrite(MODE_CTRL_OFFSET, rows[k].mode);
            repeat (2) @(posedge clk);
            check({pinsActive, spiSlaveMode, i2cSlaveMode, selectNInputEn, debounceActive,
                masterRateSel}, rows[k].outs, "mode decode");
            axiRead(MODE_CTRL_OFFSET, rows[k].mode, "mode readback");
        end
        // Disabled, then enabled in SPI slave mode: format must survive
        axiWrite(MODE_CTRL_OFFSET, 8'hA0);
        repeat (2) @(posedge clk);
        check({pinsActive, moduleClockOn, selectNInputEn}, 3'h0, "disabled pins");
        axiWrite(FORMAT_CTRL_OFFSET, 8'hFC);
        base = flagPulses;
        axiWrite(MODE_CTRL_OFFSET, 8'hA2);
        repeat (2) @(posedge clk);
        axiRead(FORMAT_CTRL_OFFSET, 8'hFC, "format kept");
        check(moduleClockOn, 1'b1, "clock on");
        check(flagPulses - base, 0, "no i2c reset in spi");
        axiWrite(MODE_CTRL_OFFSET, 8'hC0);
        base = flagPulses;
        axiWrite(MODE_CTRL_OFFSET, 8'hC2);
        repeat (3) @(posedge clk);
        check(flagPulses - base, 1, "i2c flag reset pulse");
        // Armed slave, early deselect with interrupt unmasked
        axiWrite(FORMAT_CTRL_OFFSET, 8'h04);
        axiWrite(IRQ_MASK_OFFSET, 8'h01);
        axiWrite(MODE_CTRL_OFFSET, 8'hA2);
        master.select();
        master.pulses(3);
        master.deselect();
        waitIrq();
        axiRead(MODE_CTRL_OFFSET, 8'hA3, "incomplete set");
        axiRead(FORMAT_CTRL_OFFSET, 8'h05, "complete set");
        axiRead(IRQ_STATUS_OFFSET, 8'h03, "status both");
        axiWrite(MODE_CTRL_OFFSET, 8'hA2);
        axiRead(MODE_CTRL_OFFSET, 8'hA2, "incomplete cleared");
        axiWrite(IRQ_STATUS_OFFSET, 8'h03);
        repeat (2) @(posedge clk);
        check(irq, 1'b0, "irq cleared");
        axiWrite(FORMAT_CTRL_OFFSET, 8'h04);
        // Whole byte: completion only, incomplete stays low
        master.select();
        master.pulses(8);
        @(posedge clk);
        byteDone <= 1'b1;
        @(posedge clk);
        byteDone <= 1'b0;
        master.deselect();
        repeat (10) @(posedge clk);
        axiRead(MODE_CTRL_OFFSET, 8'hA2, "no incomplete on full byte");
        axiRead(FORMAT_CTRL_OFFSET, 8'h05, "complete on full byte");
        check(irq, 1'b0, "complete masked out");
        axiWrite(FORMAT_CTRL_OFFSET, 8'h04);
        axiWrite(IRQ_STATUS_OFFSET, 8'h03);
        // Software sets the incomplete flag itself
        axiWrite(MODE_CTRL_OFFSET, 8'hA3);
        repeat (3) @(posedge clk);
        axiRead(FORMAT_CTRL_OFFSET, 8'h04, "no complete from software");
        // Master mode and disabled slave must ignore early deselect
        foreach (rows[k]) begin
            if (k < 2) begin
                v = (k == 0) ? 8'h02 : 8'hA0;
                axiWrite(MODE_CTRL_OFFSET, v);
                master.select();
                master.pulses(2);
                master.deselect();
                repeat (10) @(posedge clk);
                axiRead(MODE_CTRL_OFFSET, v, "not armed");
            end
        end
        // Mid-run reset must bring the mode, format and mask registers back to their reset values
        axiWrite(IRQ_MASK_OFFSET, 8'h03);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        check({pinsActive, irq, moduleClockOn, awready, arready}, 5'h00, "in reset");
        resetn <= 1'b1;
        @(posedge clk);
        axiRead(MODE_CTRL_OFFSET, 8'hE0, "mode after reset");
        axiRead(FORMAT_CTRL_OFFSET, 8'h00, "format after reset");
        axiRead(IRQ_MASK_OFFSET, 8'h00, "mask after reset");
        test_done();
    end
endmodule : tb_serial_iface_enable_status
`default_nettype wire
